// ===== core/fmr_field_memory_read_port.sv
// field memory with serial read port, block entry, old/new data buffering and test mode
`timescale 1ns/10ps
module fmr_field_memory_read_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // read port pins
  input wire logic output_shift_clock_i,
  input wire logic output_pointer_clear_i,
  input wire logic fetch_advance_gate_i,
  input wire logic output_drive_gate_i,
  output logic [11:0] output_word_pins_o,
  output logic output_word_pins_oe_o,
  // write port pins
  input wire logic input_shift_clock_i,
  input wire logic input_pointer_clear_i,
  input wire logic input_advance_gate_i,
  input wire logic input_mask_gate_i,
  input wire logic [11:0] input_word_pins_i,
  // status
  output logic test_mode_o,
  output logic refresh_strobe_o,
  output logic [12:0] refresh_block_o
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] rd_s1_ff;
  logic [3:0] rd_s2_ff;
  logic [15:0] wr_s1_ff;
  logic [15:0] wr_s2_ff;
  logic rck_q_ff;
  logic rclr_q_ff;
  logic wck_q_ff;
  logic wclr_q_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_s1_ff <= '0;
      rd_s2_ff <= '0;
      wr_s1_ff <= '0;
      wr_s2_ff <= '0;
    end else begin
      rd_s1_ff <= {output_shift_clock_i, output_pointer_clear_i, fetch_advance_gate_i,
                   output_drive_gate_i};
      rd_s2_ff <= rd_s1_ff;
      wr_s1_ff <= {input_shift_clock_i, input_pointer_clear_i, input_advance_gate_i,
                   input_mask_gate_i, input_word_pins_i};
      wr_s2_ff <= wr_s1_ff;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rck_q_ff <= 1'b0;
      rclr_q_ff <= 1'b0;
      wck_q_ff <= 1'b0;
      wclr_q_ff <= 1'b0;
    end else begin
      rck_q_ff <= rd_s2_ff[3];
      rclr_q_ff <= rd_s2_ff[2];
      wck_q_ff <= wr_s2_ff[15];
      wclr_q_ff <= wr_s2_ff[14];
    end
  end

  logic re;
  logic oe;
  logic rd_edge;
  logic rclr_rise;
  logic we;
  logic ie;
  logic [11:0] wdata;
  logic w_edge;
  logic wclr_rise;

  assign re = rd_s2_ff[1];
  assign oe = rd_s2_ff[0];
  assign rd_edge = rd_s2_ff[3] && !rck_q_ff;
  assign rclr_rise = rd_s2_ff[2] && !rclr_q_ff;
  assign we = wr_s2_ff[13];
  assign ie = wr_s2_ff[12];
  assign wdata = wr_s2_ff[11:0];
  assign w_edge = wr_s2_ff[15] && !wck_q_ff;
  assign wclr_rise = wr_s2_ff[14] && !wclr_q_ff;

  // ****************************************************************
  // storage and arbitration
  // ****************************************************************
  logic [11:0] mem_q [fmr_pkg::DEPTH];
  fmr_arb_if arb_if();
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [fmr_pkg::FIFO_W-1:0] fifo_in_data;
  logic [fmr_pkg::FIFO_W-1:0] fifo_out_data;

  fmr_arbiter u_arbiter (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .arb(arb_if.arb)
  );

  fmr_word_fifo #(
    .W(fmr_pkg::FIFO_W),
    .D(fmr_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(arb_if.wr_req),
    .out_ready_i(arb_if.wr_gnt),
    .out_data_o(fifo_out_data)
  );

  always_ff @(posedge clk_i) begin
    if (arb_if.wr_gnt) begin
      mem_q[fifo_out_data[29:12]] <= fifo_out_data[11:0];
    end
  end

  assign refresh_strobe_o = arb_if.ref_gnt;
  assign refresh_block_o = arb_if.ref_blk;

  // ****************************************************************
  // read pointer clear and block entry sequencer
  // ****************************************************************
  fmr_pkg::fmr_rd_state_e state_ff;
  logic rclr_pend_ff;
  logic [4:0] step_ff;
  logic [12:0] blk_ff;
  logic hiz_ff;
  logic [17:0] rptr_ff;
  logic [4:0] nxt_step;
  logic pat_ok;
  logic rd_reset;
  logic ptr_live;
  logic blk_load;
  logic rd_shift;

  assign nxt_step = 5'(step_ff + 5'h01);
  assign pat_ok = (nxt_step <= fmr_pkg::PAT_LOW_EDGES) ? (!oe && re) : (oe && !re);
  // clear waits for an edge with the fetch gate high
  assign rd_reset = rd_edge && re && rclr_pend_ff;
  assign ptr_live = (state_ff == fmr_pkg::RD_NORMAL) || (state_ff == fmr_pkg::RD_PATTERN);
  assign blk_load = rd_edge && !rclr_rise && (state_ff == fmr_pkg::RD_LATENCY)
                    && (nxt_step == fmr_pkg::LAT_EDGES);
  assign rd_shift = rd_edge && re && oe && ptr_live && !rd_reset;
  assign arb_if.rd_req = rd_shift;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rclr_pend_ff <= 1'b0;
    end else if (rclr_rise) begin
      rclr_pend_ff <= 1'b1;
    end else if (rd_reset) begin
      rclr_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= fmr_pkg::RD_NORMAL;
      step_ff <= '0;
      blk_ff <= '0;
      hiz_ff <= 1'b0;
    end else if (rclr_rise) begin
      state_ff <= fmr_pkg::RD_NORMAL;
      hiz_ff <= 1'b0;
    end else if (rd_reset) begin
      state_ff <= fmr_pkg::RD_PATTERN;
      step_ff <= '0;
      hiz_ff <= 1'b0;
    end else if (rd_edge) begin
      unique case (state_ff)
        fmr_pkg::RD_NORMAL: begin
          step_ff <= '0;
        end
        fmr_pkg::RD_PATTERN: begin
          step_ff <= nxt_step;
          if (!pat_ok) begin
            state_ff <= fmr_pkg::RD_NORMAL;
            hiz_ff <= 1'b0;
          end else begin
            if (nxt_step == fmr_pkg::HIZ_FIRST_EDGE) begin
              hiz_ff <= 1'b1;
            end
            if (nxt_step == fmr_pkg::PAT_EDGES) begin
              state_ff <= fmr_pkg::RD_ADDR;
            end
          end
        end
        fmr_pkg::RD_ADDR: begin
          step_ff <= nxt_step;
          blk_ff <= {blk_ff[11:0], oe}; // msb first on the drive gate
          if (nxt_step == fmr_pkg::ADDR_LAST_EDGE) begin
            state_ff <= fmr_pkg::RD_LATENCY;
            step_ff <= '0;
            hiz_ff <= 1'b0;
          end
        end
        fmr_pkg::RD_LATENCY: begin
          step_ff <= nxt_step; // fetch gate held low here by the controller
          if (nxt_step == fmr_pkg::LAT_EDGES) begin
            state_ff <= fmr_pkg::RD_NORMAL;
          end
        end
        default: begin
          state_ff <= fmr_pkg::RD_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rptr_ff <= fmr_pkg::PTR_RESET;
    end else if (rd_reset) begin
      rptr_ff <= fmr_pkg::PTR_RESET;
    end else if (blk_load) begin
      rptr_ff <= fmr_pkg::block_base(blk_ff);
    end else if (rd_edge && re && ptr_live) begin
      rptr_ff <= fmr_pkg::next_addr(rptr_ff);
    end
  end

  // ****************************************************************
  // output register and pin drive
  // ****************************************************************
  logic [11:0] word_ff;
  logic drive_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_ff <= '0;
    end else if (arb_if.rd_gnt) begin
      word_ff <= mem_q[rptr_ff]; // no inversion on either path
    end
  end

  // forced release during the address phase lets the gate carry address bits
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= oe && !hiz_ff;
    end
  end

  assign output_word_pins_o = word_ff;
  assign output_word_pins_oe_o = drive_ff;

  // ****************************************************************
  // write pointer and old-data delay line
  // ****************************************************************
  logic wclr_pend_ff;
  logic [17:0] wptr_ff;
  logic [30:0] dly_q [fmr_pkg::DLY_DEPTH];
  logic [4:0] head_ff;
  logic [4:0] tail_ff;
  logic [5:0] cnt_ff;
  logic w_reset;
  logic push;
  logic pop;
  logic [30:0] tail_e;

  assign w_reset = w_edge && wclr_pend_ff;
  assign push = w_edge && we && !w_reset;
  assign tail_e = dly_q[tail_ff];
  // a word reaches the array only once 20 newer words follow it
  assign fifo_in_valid = (cnt_ff > fmr_pkg::OLD_LAG) && tail_e[30];
  assign pop = (cnt_ff > fmr_pkg::OLD_LAG) && (fifo_in_ready || !tail_e[30]);
  assign fifo_in_data = tail_e[29:0];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wclr_pend_ff <= 1'b0;
      wptr_ff <= fmr_pkg::PTR_RESET;
    end else begin
      if (wclr_rise) begin
        wclr_pend_ff <= 1'b1;
      end else if (w_reset) begin
        wclr_pend_ff <= 1'b0;
      end
      if (w_reset) begin
        wptr_ff <= fmr_pkg::PTR_RESET;
      end else if (push) begin
        wptr_ff <= fmr_pkg::next_addr(wptr_ff);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      dly_q[head_ff] <= {ie, wptr_ff, wdata};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      head_ff <= '0;
      tail_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        head_ff <= 5'(head_ff + 5'h01);
      end
      if (pop) begin
        tail_ff <= 5'(tail_ff + 5'h01);
      end
      cnt_ff <= 6'(cnt_ff + {5'h00, push} - {5'h00, pop});
    end
  end

  // ****************************************************************
  // hidden test mode
  // ****************************************************************
  logic [10:0] tm_cnt_ff;
  logic [1:0] tm_low_ff;
  logic test_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tm_cnt_ff <= '0;
      tm_low_ff <= '0;
      test_ff <= 1'b0;
    end else if (w_edge) begin
      tm_cnt_ff <= (we && wr_s2_ff[14]) ? 11'(tm_cnt_ff + 11'h001) : 11'h000;
      tm_low_ff <= wr_s2_ff[14] ? 2'h0 : 2'(tm_low_ff + 2'h1);
      if (!we || (!wr_s2_ff[14] && (2'(tm_low_ff + 2'h1) == fmr_pkg::TEST_EXIT_CLR_EDGES))) begin
        test_ff <= 1'b0;
        tm_cnt_ff <= '0;
      end else if (we && wr_s2_ff[14]
                   && (11'(tm_cnt_ff + 11'h001) == fmr_pkg::TEST_ENTRY_EDGES)) begin
        test_ff <= 1'b1;
      end
    end
  end

  assign test_mode_o = test_ff;
endmodule : fmr_field_memory_read_port

// ===== shared/fmr_pkg.sv
// constants, state codes and address helpers for the field memory read port
package fmr_pkg;

  // ****************************************************************
  // widths and address map
  // ****************************************************************
  localparam int WORD_W = 12;
  localparam int ADDR_W = 18;
  localparam int BLK_W = 13;
  // 12 mini-cache words at 0..11, then the array; printed address -12 is index 0
  localparam int DEPTH = 245772;
  localparam logic [17:0] CACHE_WORDS = 18'h0_000c;
  localparam logic [17:0] LAST_ADDR = 18'h3_c00b;
  localparam logic [17:0] BLOCK_WORDS = 18'h0_0028;
  localparam logic [17:0] PTR_RESET = 18'h0_0000;
  localparam logic [12:0] LAST_BLOCK = 13'h17ff;

  // ****************************************************************
  // read block entry sequence, counted in output shift clock edges
  // ****************************************************************
  localparam logic [4:0] PAT_LOW_EDGES = 5'h02;
  localparam logic [4:0] HIZ_FIRST_EDGE = 5'h03;
  localparam logic [4:0] PAT_EDGES = 5'h04;
  localparam logic [4:0] ADDR_LAST_EDGE = 5'h11;
  localparam logic [4:0] LAT_EDGES = 5'h14;

  // ****************************************************************
  // write side buffering and test mode
  // ****************************************************************
  localparam logic [5:0] OLD_LAG = 6'h14;
  localparam int DLY_DEPTH = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = ADDR_W + WORD_W;
  localparam logic [10:0] TEST_ENTRY_EDGES = 11'h400;
  localparam logic [1:0] TEST_EXIT_CLR_EDGES = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int REFRESH_NS = 15600;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_PERIOD_NS;
  localparam logic [8:0] REFRESH_LAST = 9'(REFRESH_CYC - 1);

  // ****************************************************************
  // types and helpers
  // ****************************************************************
  typedef enum logic [3:0] {
    RD_NORMAL  = 4'b0001,
    RD_PATTERN = 4'b0010,
    RD_ADDR    = 4'b0100,
    RD_LATENCY = 4'b1000
  } fmr_rd_state_e;

  // pointer wraparound skips the mini cache
  function automatic logic [17:0] next_addr(input logic [17:0] a);
    return (a == LAST_ADDR) ? CACHE_WORDS : 18'(a + 18'h0_0001);
  endfunction : next_addr

  function automatic logic [17:0] block_base(input logic [12:0] blk);
    return 18'(CACHE_WORDS + {5'h00, blk} * BLOCK_WORDS);
  endfunction : block_base

endpackage : fmr_pkg

// ===== shared/fmr_arb_if.sv
// array access requests and grants between the port logic and the arbiter
`timescale 1ns/10ps
interface fmr_arb_if;
  logic rd_req;
  logic wr_req;
  logic rd_gnt;
  logic wr_gnt;
  logic ref_gnt;
  logic [12:0] ref_blk;

  modport arb (
    input rd_req,
    input wr_req,
    output rd_gnt,
    output wr_gnt,
    output ref_gnt,
    output ref_blk
  );

  modport core (
    output rd_req,
    output wr_req,
    input rd_gnt,
    input wr_gnt,
    input ref_gnt,
    input ref_blk
  );
endinterface : fmr_arb_if

// ===== core/fmr_word_fifo.sv
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/10ps
module fmr_word_fifo #(
  parameter int W = 30,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic do_push;
  logic do_pop;

  // extra pointer bit tells full from empty
  assign in_ready_o = (wr_ptr_ff[AW] == rd_ptr_ff[AW]) || (wr_ptr_ff[AW-1:0] != rd_ptr_ff[AW-1:0]);
  assign out_valid_o = (wr_ptr_ff != rd_ptr_ff);
  assign out_data_o = mem_q[rd_ptr_ff[AW-1:0]];
  assign do_push = in_valid_i && in_ready_o;
  assign do_pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_q[wr_ptr_ff[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= (AW + 1)'(wr_ptr_ff + 1'b1);
      end
      if (do_pop) begin
        rd_ptr_ff <= (AW + 1)'(rd_ptr_ff + 1'b1);
      end
    end
  end
endmodule : fmr_word_fifo

// ===== core/fmr_arbiter.sv
// array arbiter: read, write and self-refresh scheduling on an internal tick
`timescale 1ns/10ps
module fmr_arbiter (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // array access
  fmr_arb_if.arb arb
);
  logic [8:0] osc_cnt_ff;
  logic ref_pend_ff;
  logic [12:0] ref_blk_ff;
  logic tick;

  // ****************************************************************
  // free-running refresh oscillator
  // ****************************************************************
  assign tick = (osc_cnt_ff == fmr_pkg::REFRESH_LAST);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_cnt_ff <= '0;
    end else begin
      osc_cnt_ff <= tick ? 9'h000 : 9'(osc_cnt_ff + 9'h001);
    end
  end

  // ****************************************************************
  // grants: read first, so output timing never waits on refresh
  // ****************************************************************
  assign arb.rd_gnt = arb.rd_req;
  assign arb.wr_gnt = arb.wr_req && !arb.rd_req;
  assign arb.ref_gnt = ref_pend_ff && !arb.rd_req && !arb.wr_req;
  assign arb.ref_blk = ref_blk_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_pend_ff <= 1'b0;
    end else if (tick) begin
      ref_pend_ff <= 1'b1;
    end else if (arb.ref_gnt) begin
      ref_pend_ff <= 1'b0;
    end
  end

  // refresh counter walks block addresses
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_blk_ff <= '0;
    end else if (arb.ref_gnt) begin
      ref_blk_ff <= (ref_blk_ff == fmr_pkg::LAST_BLOCK) ? 13'h0000 : 13'(ref_blk_ff + 13'h0001);
    end
  end
endmodule : fmr_arbiter

// ===== bench/fmr_field_memory_read_port_checker.sv
// assertion checker for the field memory read port
`timescale 1ns/10ps
module fmr_field_memory_read_port_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // read port
  input wire logic output_shift_clock_i,
  input wire logic output_pointer_clear_i,
  input wire logic fetch_advance_gate_i,
  input wire logic output_drive_gate_i,
  input wire logic [11:0] output_word_pins_o,
  input wire logic output_word_pins_oe_o,
  // write port
  input wire logic input_shift_clock_i,
  input wire logic input_pointer_clear_i,
  input wire logic input_advance_gate_i,
  input wire logic input_mask_gate_i,
  input wire logic [11:0] input_word_pins_i,
  // status
  input wire logic test_mode_o,
  input wire logic refresh_strobe_o,
  input wire logic [12:0] refresh_block_o
);
  // ****************
  // helper history
  // ****************
  logic rck_ff;
  logic [7:0] qual_ff;
  logic [15:0] wlow_ff;
  logic [12:0] hi_cnt_ff;
  logic [9:0] gap_ff;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // raw pin edges with both gates high; the synchroniser lands the word a few cycles later
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rck_ff <= 1'b0;
      qual_ff <= 8'h00;
    end else begin
      rck_ff <= output_shift_clock_i;
      qual_ff <= {qual_ff[6:0],
        output_shift_clock_i & ~rck_ff & fetch_advance_gate_i & output_drive_gate_i};
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wlow_ff <= 16'h0000;
      hi_cnt_ff <= 13'h0000;
    end else begin
      wlow_ff <= {wlow_ff[14:0], ~input_advance_gate_i | ~input_pointer_clear_i};
      if (!input_advance_gate_i || !input_pointer_clear_i) begin
        hi_cnt_ff <= 13'h0000;
      end else if (hi_cnt_ff != 13'h1fff) begin
        hi_cnt_ff <= hi_cnt_ff + 13'h0001;
      end
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gap_ff <= 10'h000;
    end else if (refresh_strobe_o) begin
      gap_ff <= 10'h000;
    end else if (gap_ff != 10'h3ff) begin
      gap_ff <= gap_ff + 10'h001;
    end
  end

  property p_oe_off;
    (!output_drive_gate_i) [*4] |-> ##1 !output_word_pins_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pins driven, gate low");
  property p_word_cause;
    $changed(output_word_pins_o) |-> |qual_ff;
  endproperty
  a_word_cause: assert property (p_word_cause) else $error("word moved w/o shift");
  // 1023 write periods of at least four cycles lie before the entering edge
  property p_test_on;
    $rose(test_mode_o) |-> hi_cnt_ff >= 13'h0ffa;
  endproperty
  a_test_on: assert property (p_test_on) else $error("test mode entered early");
  property p_test_off;
    $fell(test_mode_o) |-> |wlow_ff;
  endproperty
  a_test_off: assert property (p_test_off) else $error("test mode left w/o cause");
  property p_ref_pulse;
    refresh_strobe_o |=> !refresh_strobe_o;
  endproperty
  a_ref_pulse: assert property (p_ref_pulse) else $error("refresh strobe too long");
  property p_ref_step;
    refresh_strobe_o |=> refresh_block_o == (($past(refresh_block_o) == 13'h17ff) ?
      13'h0000 : $past(refresh_block_o) + 13'h0001);
  endproperty
  a_ref_step: assert property (p_ref_step) else $error("refresh block step wrong");
  property p_ref_hold;
    $changed(refresh_block_o) |-> $past(refresh_strobe_o);
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("refresh block moved alone");
  property p_ref_gap;
    gap_ff <= 10'h1c2;
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("refresh overdue");
  c_test: cover property ($rose(test_mode_o));
  c_ref: cover property (refresh_strobe_o);
  c_shift: cover property ($changed(output_word_pins_o));
endmodule : fmr_field_memory_read_port_checker

bind fmr_field_memory_read_port fmr_field_memory_read_port_checker i_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .output_shift_clock_i(output_shift_clock_i),
  .output_pointer_clear_i(output_pointer_clear_i), .fetch_advance_gate_i(fetch_advance_gate_i),
  .output_drive_gate_i(output_drive_gate_i), .output_word_pins_o(output_word_pins_o),
  .output_word_pins_oe_o(output_word_pins_oe_o), .input_shift_clock_i(input_shift_clock_i),
  .input_pointer_clear_i(input_pointer_clear_i), .input_advance_gate_i(input_advance_gate_i),
  .input_mask_gate_i(input_mask_gate_i), .input_word_pins_i(input_word_pins_i),
  .test_mode_o(test_mode_o), .refresh_strobe_o(refresh_strobe_o),
  .refresh_block_o(refresh_block_o)
);

// ===== bench/fmr_ctrl_model.sv
// write side controller model driving the write port pins
`timescale 1ns/10ps
module fmr_ctrl_model (
  // clock
  input wire logic clk_i,
  // write port pins
  output logic input_shift_clock_o,
  output logic input_pointer_clear_o,
  output logic input_advance_gate_o,
  output logic input_mask_gate_o,
  output logic [11:0] input_word_o
);
  initial begin
    input_shift_clock_o = 1'b0;
    input_pointer_clear_o = 1'b0;
    input_advance_gate_o = 1'b0;
    input_mask_gate_o = 1'b1;
    input_word_o = 12'h000;
  end

  // one write clock, called at a falling clk edge; lo_cyc sets a prompt or slow pace
  task automatic wr_edge(input logic adv, input logic clr, input logic [11:0] d,
    input int lo_cyc);
    input_advance_gate_o = adv;
    input_pointer_clear_o = clr;
    // unused data lines toggle so a stale word never looks valid
    input_word_o = adv ? d : ~input_word_o;
    repeat (lo_cyc) @(negedge clk_i);
    input_shift_clock_o = 1'b1;
    repeat (2) @(negedge clk_i);
    input_shift_clock_o = 1'b0;
  endtask : wr_edge

  task automatic wr_init();
    repeat (12) wr_edge(1'b0, 1'b0, 12'h000, 3);
    wr_edge(1'b1, 1'b1, 12'h000, 2);
  endtask : wr_init
endmodule : fmr_ctrl_model

// ===== bench/fmr_field_memory_read_port_tb.sv
// self-checking bench for the field memory read port
`timescale 1ns/10ps
module fmr_field_memory_read_port_tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic rck = 1'b0;
  logic rclr = 1'b0;
  logic fetch = 1'b0;
  logic drive = 1'b0;
  logic [11:0] word;
  logic oe, wck, wclr, wadv, wmask, test_mode, strobe;
  logic [11:0] wdata;
  logic [12:0] rblk;
  logic [11:0] img [0:127];
  logic [11:0] exp_q [$];
  logic [11:0] last_w = 12'h000;
  logic [11:0] e;
  logic [15:0] rnd = 16'h0035;
  int error_cnt = 0;
  int n_checks = 0;
  int n_strobe = 0;

  always #25 clk_i = ~clk_i;

  fmr_field_memory_read_port i_fmr_field_memory_read_port (
    .clk_i(clk_i), .nrst_i(nrst_i), .output_shift_clock_i(rck),
    .output_pointer_clear_i(rclr), .fetch_advance_gate_i(fetch), .output_drive_gate_i(drive),
    .output_word_pins_o(word), .output_word_pins_oe_o(oe), .input_shift_clock_i(wck),
    .input_pointer_clear_i(wclr), .input_advance_gate_i(wadv), .input_mask_gate_i(wmask),
    .input_word_pins_i(wdata), .test_mode_o(test_mode), .refresh_strobe_o(strobe),
    .refresh_block_o(rblk)
  );
  fmr_ctrl_model i_fmr_ctrl_model (
    .clk_i(clk_i), .input_shift_clock_o(wck), .input_pointer_clear_o(wclr),
    .input_advance_gate_o(wadv), .input_mask_gate_o(wmask), .input_word_o(wdata)
  );

  // ****************
  // helpers
  // ****************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input string what, input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // read clock period of seven cycles keeps every phase at or above the two-cycle minimum
  task automatic rd_edge(input logic f, input logic d);
    fetch = f;
    drive = d;
    repeat (2) @(negedge clk_i);
    rck = 1'b1;
    repeat (2) @(negedge clk_i);
    rck = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : rd_edge

  task automatic rd_word(input int idx);
    exp_q.push_back(img[idx]);
    rd_edge(1'b1, 1'b1);
    chk("oe on", 13'(oe), 13'h0001);
  endtask : rd_word

  task automatic rd_clear();
    rclr = 1'b1;
    rd_edge(1'b1, 1'b0);
    rclr = 1'b0;
  endtask : rd_clear

  task automatic blk_enter(input logic [12:0] blk);
    rd_clear();
    repeat (2) rd_edge(1'b1, 1'b0);
    repeat (2) rd_edge(1'b0, 1'b1);
    chk("oe entry", 13'(oe), 13'h0000);
    for (int i = 12; i >= 0; i--) rd_edge(1'b0, blk[i]);
    repeat (20) rd_edge(1'b0, 1'b0);
  endtask : blk_enter

  // ****************
  // output watcher and run
  // ****************
  always @(posedge clk_i) if (nrst_i && strobe === 1'b1) n_strobe++;

  always @(negedge clk_i) begin
    if (nrst_i && word !== last_w) begin
      last_w = word;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hxxx;
      chk("word", 13'(word), 13'(e));
    end
  end

  initial begin
    #(50 * 20000);
    error_cnt++;
    $display("CHECK FAILED watchdog expected done seen hang");
    final_report();
  end

  initial begin
    for (int i = 0; i < 128; i++) begin
      rnd = lfsr(rnd);
      img[i] = {7'(i + 1), rnd[4:0]};
    end
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    chk("oe reset", 13'(oe), 13'h0000);
    chk("test reset", 13'(test_mode), 13'h0000);
    repeat (2000) @(negedge clk_i);
    fork
      begin
        repeat (12) rd_edge(1'b0, 1'b0);
        rd_clear();
      end
      i_fmr_ctrl_model.wr_init();
    join
    for (int i = 0; i < 100; i++) i_fmr_ctrl_model.wr_edge(1'b1, 1'b0, img[i], 2);
    rd_clear();
    for (int i = 0; i < 4; i++) rd_word(i);
    repeat (2) rd_edge(1'b0, 1'b1);
    rd_word(4);
    repeat (2) rd_edge(1'b1, 1'b0);
    chk("oe off", 13'(oe), 13'h0000);
    rd_word(7);
    rd_clear();
    repeat (2) rd_edge(1'b1, 1'b0);
    repeat (6) rd_edge(1'b0, 1'b1);
    rd_clear();
    rd_word(0);
    rd_word(1);
    blk_enter(13'h0001);
    for (int i = 52; i < 55; i++) rd_word(i);
    blk_enter(13'h0000);
    rd_word(12);
    i_fmr_ctrl_model.wr_edge(1'b1, 1'b1, 12'h000, 2);
    for (int i = 0; i < 5; i++) i_fmr_ctrl_model.wr_edge(1'b1, 1'b0, ~img[i], 2);
    rd_clear();
    for (int i = 0; i < 5; i++) rd_word(i);
    // masked writes below must leave the array untouched
    i_fmr_ctrl_model.input_mask_gate_o = 1'b0;
    for (int i = 0; i < 1024; i++) begin
      if (i == 1023) chk("test early", 13'(test_mode), 13'h0000);
      rnd = lfsr(rnd);
      i_fmr_ctrl_model.wr_edge(1'b1, 1'b1, rnd[11:0], 2);
    end
    repeat (3) @(negedge clk_i);
    chk("test on", 13'(test_mode), 13'h0001);
    i_fmr_ctrl_model.wr_edge(1'b0, 1'b1, 12'h000, 2);
    repeat (3) @(negedge clk_i);
    chk("test off", 13'(test_mode), 13'h0000);
    rd_clear();
    exp_q.push_back(~img[0]);
    rd_edge(1'b1, 1'b1);
    repeat (4) rd_edge(1'b1, 1'b0);
    rd_word(5);
    chk("refresh block", rblk, 13'(n_strobe));
    chk("words left", 13'(exp_q.size()), 13'h0000);
    final_report();
  end
endmodule : fmr_field_memory_read_port_tb
